// ### csrr_pkg.sv
// Package for the chip settings report responder.
// Assumes a single clock domain; the report is a 64-byte array.
package csrr_pkg;
  localparam int unsigned REPORT_BYTES   = 64;
  localparam logic [7:0]  CMD_READ_SET   = 8'h20;
  localparam logic [7:0]  STATUS_OK      = 8'h00;
  localparam int unsigned IDX_CMD        = 0;
  localparam int unsigned IDX_STATUS     = 1;
  localparam int unsigned IDX_PIN_FUNC0  = 4;
  localparam int unsigned IDX_PIN8_FUNC  = 12;
  localparam int unsigned IDX_OUT_LO     = 13;
  localparam int unsigned IDX_OUT_HI     = 14;
  localparam int unsigned IDX_DIR_LO     = 15;
  localparam int unsigned IDX_DIR_HI     = 16;
  localparam int unsigned IDX_OTHER      = 17;
  localparam int unsigned IDX_ACCESS     = 18;
  localparam int unsigned BIT_WAKE       = 4;
  localparam int unsigned BIT_BUS_HOLD   = 0;
  localparam logic [7:0]  FUNC_GPIO      = 8'h00;
  localparam logic [7:0]  FUNC_CS        = 8'h01;
  localparam logic [7:0]  FUNC_DEDICATED = 8'h02;
  localparam logic [7:0]  ACCESS_OPEN    = 8'h00;
  localparam logic [7:0]  ACCESS_PASSWD  = 8'h40;
  localparam logic [7:0]  ACCESS_LOCKED  = 8'h80;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [5:0]  IDX_RESET      = 6'h00;
  typedef enum logic [1:0] {
    CSRR_IDLE = 2'b00,
    CSRR_COLLECT = 2'b01,
    CSRR_SEND = 2'b10
  } csrr_state_e;
  typedef enum logic [2:0] {
    CSRR_CNT_NONE = 3'b000,
    CSRR_CNT_FALL = 3'b001,
    CSRR_CNT_RISE = 3'b010,
    CSRR_CNT_LOW = 3'b011,
    CSRR_CNT_HIGH = 3'b100
  } csrr_count_e;
endpackage

// ### csrr_responder.sv
// Chip settings report responder: takes a 64-byte command report byte by byte
// and, for the read-settings command, streams back a 64-byte settings report.
// Assumes the report source and sink share mclk_i with this block.
// Settings inputs come from logic on the same clock and are read as each
// reply byte is loaded, so they must stay steady while a reply is out.
// Commands other than read-settings are swallowed whole and get no reply.
//
// Notes on behaviour
// - Response byte 0 echoes the read-settings command code.
// - Response byte 1 holds the success status on success.
// - Bytes 4-11 give pin 0-7 functions; byte 12 gives pin 8 function.
// - Byte 13 holds default output levels, pin 7 in MSB; byte 14 meaningless.
// - Byte 15 holds default directions, pin 7 in MSB; byte 16 meaningless.
// - Byte 17 bit 4 shows remote wake-up enable; bits 7-5 meaningless.
// - Byte 17 bits 3-1 encode interrupt counting mode; 5-7 reserved.
// - Byte 17 bit 0 shows whether the SPI bus is held between transfers.
// - Byte 18 shows nonvolatile access level: open, password, or locked.
`timescale 1ns/10ps
`default_nettype none
module csrr_responder (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  // Incoming command report bytes
  input  wire logic                 cmd_valid_i,
  input  wire logic [7:0]           cmd_byte_i,
  output logic                      cmd_ready_o,
  // Outgoing response report bytes
  output logic                      rsp_valid_o,
  output logic [7:0]                rsp_byte_o,
  output logic                      rsp_last_o,
  input  wire logic                 rsp_ready_i,
  // Current volatile settings
  input  wire logic [8*8-1:0]       pin_func_i,
  input  wire logic [7:0]           input_only_pin_8_func_i,
  input  wire logic [7:0]           default_output_i,
  input  wire logic [7:0]           default_direction_i,
  input  wire logic                 wake_enable_i,
  input  wire csrr_pkg::csrr_count_e count_mode_i,
  input  wire logic                 bus_hold_i,
  input  wire logic [7:0]           access_level_i
);
  import csrr_pkg::*;

  csrr_state_e state_q;
  csrr_state_e state_d;
  logic [5:0]  idx_q;
  logic [5:0]  idx_d;
  logic        is_read_q;
  logic        is_read_d;
  logic        cmd_ready_q;
  logic        rsp_valid_q;
  logic [7:0]  rsp_byte_q;
  logic        rsp_last_q;
  logic [7:0]  report [REPORT_BYTES];

  // True when the index points at the final byte of a report.
  function automatic logic is_final_idx(input logic [5:0] idx);
    return idx == 6'(REPORT_BYTES - 1);
  endfunction

  wire logic  cmd_take    = cmd_valid_i && cmd_ready_q;
  wire logic  cmd_end     = cmd_take && is_final_idx(idx_q);
  wire logic  rsp_take    = rsp_valid_q && rsp_ready_i;
  wire logic  rsp_move    = !rsp_valid_q || rsp_ready_i;
  wire logic  send_end    = rsp_take && rsp_last_q;
  wire logic  in_send     = (state_q == CSRR_SEND);
  wire logic  load_byte   = in_send && rsp_move && !rsp_last_q;
  wire logic  load_final  = load_byte && is_final_idx(idx_q);

  // Field bytes of the reply other than the pin functions, each a named wire so the image is a plain selection.
  wire logic [7:0] echo_byte   = CMD_READ_SET;
  wire logic [7:0] status_byte = STATUS_OK;
  wire logic [7:0] pin8_byte   = input_only_pin_8_func_i;
  wire logic [7:0] out_lo_byte = default_output_i;
  wire logic [7:0] dir_lo_byte = default_direction_i;
  // The upper halves of the level and direction fields carry nothing and read zero.
  wire logic [7:0] out_hi_byte = BYTE_ZERO;
  wire logic [7:0] dir_hi_byte = BYTE_ZERO;
  // Bits 7-5 read zero, wake-up sits in bit 4, the counting mode in 3-1, bus hold in 0.
  wire logic [7:0] other_byte  = {3'b000, wake_enable_i, count_mode_i, bus_hold_i};
  wire logic [7:0] access_byte = access_level_i;

  // Report image; every byte without a field reads zero so the host never sees
  // stale data from an earlier reply.
  for (genvar g = 0; g < REPORT_BYTES; g++) begin : g_report
    if (g == IDX_CMD) begin : g_cmd
      assign report[g] = echo_byte;
    end else if (g == IDX_STATUS) begin : g_status
      assign report[g] = status_byte;
    end else if (g >= IDX_PIN_FUNC0 && g < IDX_PIN8_FUNC) begin : g_pin
      assign report[g] = pin_func_i[(g - IDX_PIN_FUNC0) * 8 +: 8];
    end else if (g == IDX_PIN8_FUNC) begin : g_pin8
      assign report[g] = pin8_byte;
    end else if (g == IDX_OUT_LO) begin : g_out_lo
      assign report[g] = out_lo_byte;
    end else if (g == IDX_OUT_HI) begin : g_out_hi
      assign report[g] = out_hi_byte;
    end else if (g == IDX_DIR_LO) begin : g_dir_lo
      assign report[g] = dir_lo_byte;
    end else if (g == IDX_DIR_HI) begin : g_dir_hi
      assign report[g] = dir_hi_byte;
    end else if (g == IDX_OTHER) begin : g_other
      assign report[g] = other_byte;
    end else if (g == IDX_ACCESS) begin : g_access
      assign report[g] = access_byte;
    end else begin : g_zero
      assign report[g] = BYTE_ZERO;
    end
  end

  // Command intake counts all 64 bytes before any reply starts, so a short or
  // long report from the host shifts every later command by the difference.
  // In the send state the index walks the image one byte per accepted beat.
  always_comb begin
    state_d   = state_q;
    idx_d     = idx_q;
    is_read_d = is_read_q;
    unique case (state_q)
      CSRR_IDLE: begin
        if (cmd_take) begin
          // Byte 0 decides; reserved bytes that follow are swallowed.
          is_read_d = (cmd_byte_i == CMD_READ_SET);
          idx_d     = 6'h01;
          state_d   = CSRR_COLLECT;
        end
      end
      CSRR_COLLECT: begin
        if (cmd_end) begin
          idx_d   = IDX_RESET;
          state_d = is_read_q ? CSRR_SEND : CSRR_IDLE;
        end else if (cmd_take) begin
          idx_d = idx_q + 6'h01;
        end
      end
      CSRR_SEND: begin
        if (load_byte) begin
          idx_d = idx_q + 6'h01;
        end
        if (send_end) begin
          idx_d   = IDX_RESET;
          state_d = CSRR_IDLE;
        end
      end
      default: begin
        state_d = CSRR_IDLE;
        idx_d   = IDX_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_q   <= CSRR_IDLE;
      idx_q     <= IDX_RESET;
      is_read_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      idx_q     <= idx_d;
      is_read_q <= is_read_d;
    end
  end

  // The ready flag follows the next state so that, for a read command, it drops on the very edge
  // that takes byte 63; waiting a cycle would let one stray byte slip in.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cmd_ready_q <= 1'b0;
    end else begin
      cmd_ready_q <= (state_d != CSRR_SEND);
    end
  end

  // Output stage: one byte per accepted beat, held while the sink stalls.
  // A new byte is loaded on the edge that hands the old one over, so a sink
  // that never stalls sees one byte per cycle with no bubble.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rsp_valid_q <= 1'b0;
      rsp_byte_q  <= BYTE_ZERO;
      rsp_last_q  <= 1'b0;
    end else if (load_byte) begin
      rsp_valid_q <= 1'b1;
      rsp_byte_q  <= report[idx_q];
      rsp_last_q  <= load_final;
    end else if (rsp_take) begin
      rsp_valid_q <= 1'b0;
      rsp_last_q  <= 1'b0;
    end
  end

  assign cmd_ready_o = cmd_ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_byte_o  = rsp_byte_q;
  assign rsp_last_o  = rsp_last_q;
endmodule
`default_nettype wire

// ### csrr_monitor.sv
// Checker of the settings reply stream.
// Bound into csrr_responder; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module csrr_monitor (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  // Command stream
  input wire logic       cmd_ready_o,
  // Reply stream
  input wire logic       rsp_valid_o,
  input wire logic       rsp_ready_i,
  input wire logic       rsp_last_o,
  input wire logic [7:0] rsp_byte_o,
  input wire logic [7:0] access_level_i
);
  logic [5:0]      idx_q;
  wire logic [7:0] b = rsp_byte_o;
  function automatic logic at(input int lo, input int hi);
    return rsp_valid_o && idx_q >= lo && idx_q <= hi;
  endfunction
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) idx_q <= 6'h00;
    else if (rsp_valid_o && rsp_ready_i) idx_q <= idx_q + 6'h01;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_echo_cmd: assert property ($rose(rsp_valid_o) |-> b == 8'h20) else $error("echo");
  a_status_ok: assert property (at(0, 0) && rsp_ready_i |=> at(1, 1) && b == 8'h00)
    else $error("status");
  a_pin_func: assert property (at(4, 11) |-> b < 8'h03) else $error("func");
  a_pin8_func: assert property (at(12, 12) |-> b == 8'h00 || b == 8'h02) else $error("p8");
  a_mode_code: assert property (at(17, 17) |-> b[3:1] < 3'h5) else $error("mode");
  a_access_lvl: assert property (at(18, 18) |-> b == access_level_i) else $error("acc");
  a_zero_fill: assert property (at(2, 3) || at(19, 63) |-> b == 8'h00) else $error("fill");
  a_last_mark: assert property (rsp_valid_o |-> rsp_last_o == at(63, 63)) else $error("last");
  a_busy_refuse: assert property (rsp_valid_o |-> !cmd_ready_o) else $error("busy");
  c_reply: cover property (at(0, 0));
  c_stall: cover property (rsp_valid_o && !rsp_ready_i);
  c_done: cover property (rsp_last_o && rsp_ready_i);
endmodule
bind csrr_responder csrr_monitor u_mon (.mclk_i, .rst_b_i, .cmd_ready_o, .rsp_valid_o, .rsp_ready_i,
  .rsp_last_o, .rsp_byte_o, .access_level_i);
`default_nettype wire

// ### csrr_host.sv
// Host model: sends whole 64-byte command reports and sinks the reply.
// Shares mclk_i with the responder and drives on falling edges.
`timescale 1ns/10ps
`default_nettype none
module csrr_host (
  // Clock
  input wire logic       mclk_i,
  // Command and reply streams
  input wire logic       cmd_ready_i,
  input wire logic       rsp_valid_i,
  input wire logic [7:0] rsp_byte_i,
  input wire logic       rsp_last_i,
  output var logic       cmd_valid_o,
  output var logic [7:0] cmd_byte_o,
  output var logic       rsp_ready_o
);
  logic       slow = 1'b0;
  logic [7:0] got[$];
  int         last_at = -1;
  initial {cmd_valid_o, cmd_byte_o, rsp_ready_o} = 10'h001;
  // When slow is set the sink refuses every other cycle.
  always @(negedge mclk_i) rsp_ready_o <= !slow || !rsp_ready_o;
  always @(posedge mclk_i) if (rsp_valid_i && rsp_ready_o) begin
    if (rsp_last_i) last_at = got.size();
    got.push_back(rsp_byte_i);
  end
  task automatic send(input logic [7:0] code);
    for (int i = 0; i < 64; i++) begin
      @(negedge mclk_i);
      cmd_valid_o = 1'b1;
      cmd_byte_o  = i ? 8'h00 : code;
      do @(posedge mclk_i); while (!cmd_ready_i);
    end
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o  = ~cmd_byte_o;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Testbench: the host model sends reports, each reply is checked byte by byte.
// Settings are held steady while a reply is out.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, y) begin checks_done++; if ((x) !== (y)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, x, y); end end
module tb;
  import csrr_pkg::*;
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, cmd_valid_i, cmd_ready_o, rsp_valid_o;
  logic        rsp_last_o, rsp_ready_i, wake_enable_i, bus_hold_i;
  logic [7:0]  cmd_byte_i, rsp_byte_o, input_only_pin_8_func_i, access_level_i;
  logic [7:0]  default_output_i, default_direction_i;
  logic [63:0] pin_func_i;
  csrr_count_e count_mode_i;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  csrr_responder dut (.mclk_i, .rst_b_i, .cmd_valid_i, .cmd_byte_i, .cmd_ready_o, .rsp_valid_o,
    .rsp_byte_o, .rsp_last_o, .rsp_ready_i, .pin_func_i, .input_only_pin_8_func_i,
    .default_output_i, .default_direction_i, .wake_enable_i, .count_mode_i, .bus_hold_i,
    .access_level_i);
  csrr_host host (.mclk_i, .cmd_ready_i(cmd_ready_o), .rsp_valid_i(rsp_valid_o),
    .rsp_byte_i(rsp_byte_o), .rsp_last_i(rsp_last_o), .cmd_valid_o(cmd_valid_i),
    .cmd_byte_o(cmd_byte_i),
    .rsp_ready_o(rsp_ready_i));
  function automatic logic [7:0] exp_byte(input int i);
    if (i == 0) return 8'h20;
    if (i >= 4 && i < 12) return pin_func_i[(i - 4) * 8 +: 8];
    if (i == 12) return input_only_pin_8_func_i;
    if (i == 13) return default_output_i;
    if (i == 15) return default_direction_i;
    if (i == 17) return {3'h0, wake_enable_i, count_mode_i, bus_hold_i};
    return (i == 18) ? access_level_i : 8'h00;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (++cyc == 3000) begin
    miscompares++;
    end_of_test();
  end
  initial begin
    {pin_func_i, input_only_pin_8_func_i, default_output_i, default_direction_i} = '0;
    {wake_enable_i, bus_hold_i, access_level_i} = '0;
    count_mode_i = CSRR_CNT_NONE;
    repeat (4) @(negedge mclk_i);
    rst_b_i = 1'b1;
    // Another command code is swallowed without a reply.
    host.send(8'h21);
    repeat (80) @(negedge mclk_i);
    `CHK("silent", 0, host.got.size())
    for (int k = 0; k < 5; k++) begin
      for (int p = 0; p < 8; p++) pin_func_i[p * 8 +: 8] = 8'((p + k) % 3);
      input_only_pin_8_func_i = k[0] ? 8'h02 : 8'h00;
      default_output_i = 8'(8'h36 + k);
      default_direction_i = 8'(8'hc1 - k);
      {wake_enable_i, bus_hold_i, host.slow} = 3'(k);
      count_mode_i = csrr_count_e'(k);
      access_level_i = 8'(k % 3) << 6;
      host.got.delete();
      host.last_at = -1;
      host.send(8'h20);
      while (host.got.size() < 64) @(negedge mclk_i);
      for (int i = 0; i < 64; i++) `CHK("reply", exp_byte(i), host.got[i])
      `CHK("last", 63, host.last_at)
      `CHK("ready", 1'b1, cmd_ready_o)
    end
    end_of_test();
  end
endmodule
`default_nettype wire
